/* File: hw/frps_pkg.sv */
package frps_pkg;
  // Power-fail stop selection codes
  localparam logic [1:0] PFS_COAST = 2'h0;
  localparam logic [1:0] PFS_STOP = 2'h1;
  localparam logic [1:0] PFS_CONTINUE = 2'h2;
  // Restart coast time value meaning "automatic restart disabled"
  localparam logic [13:0] COAST_DISABLE = 14'h270f;
  // Output terminal function codes
  localparam logic [7:0] TERM_PFD_POS = 8'h2e;
  localparam logic [7:0] TERM_PFD_NEG = 8'h92;
  localparam logic [7:0] TERM_RETRY_POS = 8'h40;
  localparam logic [7:0] TERM_RETRY_NEG = 8'ha4;
  localparam int NUM_TERMS = 3;
  // Retry count limit encoding
  localparam logic [6:0] RETRY_MAX_DIRECT = 7'h0a;
  localparam logic [6:0] RETRY_FAULT_OUT_BASE = 7'h64;
  // Fault selection settings
  localparam logic [2:0] RSEL_ALL = 3'h0;
  localparam logic [2:0] RSEL_OC = 3'h1;
  localparam logic [2:0] RSEL_OV = 3'h2;
  localparam logic [2:0] RSEL_OC_OV = 3'h3;
  localparam logic [2:0] RSEL_NO_THERMAL = 3'h4;
  localparam logic [2:0] RSEL_OC_ACC_DEC = 3'h5;
  // Fault vector bit positions
  localparam int F_OC_ACC = 0;
  localparam int F_OC_CONST = 1;
  localparam int F_OC_DEC = 2;
  localparam int F_OV_ACC = 3;
  localparam int F_OV_CONST = 4;
  localparam int F_OV_DEC = 5;
  localparam int F_MOTOR_OL = 6;
  localparam int F_DRIVE_OL = 7;
  localparam int F_EXT_THERM = 8;
  localparam int F_PHASE_LOSS = 9;
  localparam int F_OTHER = 10;
  localparam int NUM_FAULTS = 11;
  // Timing: wait is set in 0.1 s units, tick is 0.1 s
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [11:0] WAIT_MAX = 12'he10;
  localparam logic [11:0] WAIT_MIN = 12'h001;
  localparam logic [11:0] WAIT_RESET = 12'h00a;
  localparam int SUCCESS_FACTOR = 4;
endpackage : frps_pkg

/* File: hw/frps_tick_if.sv */
`timescale 1ns/1ps
interface frps_tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface : frps_tick_if

/* File: hw/frps_tick.sv */
`timescale 1ns/1ps
module frps_tick #(
  parameter int TICK_CYC = frps_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Tick out
  frps_tick_if.source tk
);
  import frps_pkg::*;
  logic [21:0] count;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 22'h0;
      tk.tick <= 1'b0;
    end else if (count == 22'(TICK_CYC - 1)) begin
      count <= 22'h0;
      tk.tick <= 1'b1;
    end else begin
      count <= count + 22'h1;
      tk.tick <= 1'b0;
    end
  end
endmodule : frps_tick

/* File: hw/frps_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Default selection: shut output, motor coasts
// - Power-fail decel holds bus down to 0 Hz
// - Mode 1: finish decel, restart needs start toggle
// - After power-fail stop, held start refused
// - Coast time set: use auto restart instead
// - Mode 2: power return re-accelerates to setpoint
// - Mode 2 start dropped: normal deceleration
// - Flag during power-fail decel and stop after
// - Flag on terminals coded 46 or 146
// - No power-fail stop when stopped or tripped
// - After wait, auto reset, restart at start freq
// - Count 0 disables; 1..10 direct retries
// - Retries exceeded: retry-excess trip, no more retries
// - Wait 0..360 s, default 1 s, zero means 0.1 s
// - Success after four waits fault-free, count up
// - Success clears consecutive failure count
// - Success count readable, zero write clears it
// - Retry flag on terminals coded 64 or 164
// - Fault selection chooses retry-eligible trips
// - Only the first fault of a sequence stored
// - Retry reset keeps thermal and brake data
// - Auto restart enabled: retry uses restart operation
module frps_top #(
  parameter int TICK_CYC = frps_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Settings
  input wire logic [1:0] power_fail_stop_select,
  input wire logic [13:0] restart_coast_time,
  input wire logic [2:0] retry_fault_select,
  input wire logic [6:0] retry_count_limit,
  input wire logic [11:0] retry_wait_time,
  input wire logic [7:0] output_terminal_function_select [frps_pkg::NUM_TERMS],
  // Success counter access
  input wire logic retry_success_clear,
  // Power stage status and start inputs
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  input wire logic power_fail_detect,
  input wire logic freq_zero,
  input wire logic [frps_pkg::NUM_FAULTS-1:0] fault_code,
  // Commands to power stage
  output logic output_shutoff,
  output logic pf_decel_cmd,
  output logic normal_decel_cmd,
  output logic reaccel_cmd,
  output logic run_enable,
  output logic retry_restart,
  output logic flying_restart,
  output logic trip,
  output logic fault_output,
  output logic retry_excess_fault,
  output logic clear_thermal_data,
  // Status
  output logic power_fail_decel_flag,
  output logic retry_active_flag,
  output logic [frps_pkg::NUM_TERMS-1:0] terminal_out,
  output logic [15:0] retry_success_counter,
  output logic [frps_pkg::NUM_FAULTS-1:0] first_fault
);
  import frps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic fault_eligible(input logic [2:0] sel, input logic [NUM_FAULTS-1:0] f);
    logic oc;
    logic ov;
    logic therm;
    oc = f[F_OC_ACC] | f[F_OC_CONST] | f[F_OC_DEC];
    ov = f[F_OV_ACC] | f[F_OV_CONST] | f[F_OV_DEC];
    therm = f[F_MOTOR_OL] | f[F_DRIVE_OL] | f[F_EXT_THERM];
    unique case (sel)
      RSEL_ALL: fault_eligible = |f;
      RSEL_OC: fault_eligible = oc;
      RSEL_OV: fault_eligible = ov;
      RSEL_OC_OV: fault_eligible = oc | ov;
      RSEL_NO_THERMAL: fault_eligible = oc | ov | f[F_PHASE_LOSS] | f[F_OTHER];
      RSEL_OC_ACC_DEC: fault_eligible = f[F_OC_ACC] | f[F_OC_DEC];
      default: fault_eligible = 1'b0;
    endcase
  endfunction : fault_eligible

  function automatic logic term_drive(input logic [7:0] code, input logic [7:0] pos, input logic [7:0] neg,
                                      input logic flag);
    term_drive = (code == pos) ? flag : (code == neg) ? ~flag : 1'b0;
  endfunction : term_drive

  frps_tick_if tk_if ();
  frps_tick #(.TICK_CYC(TICK_CYC)) u_tick (.clk(clk), .arst_n(arst_n), .tk(tk_if));

  logic start_in;
  logic start_prev;
  logic start_rise;
  logic auto_restart_en;
  logic any_fault;
  logic [6:0] retry_limit;
  logic [11:0] wait_ticks;
  assign start_in = forward_start_input | reverse_start_input;
  assign start_rise = start_in & ~start_prev;
  assign auto_restart_en = restart_coast_time != COAST_DISABLE;
  assign any_fault = |fault_code;
  // Zero wait is treated as one tick; oversize settings are clamped
  assign wait_ticks = (retry_wait_time == 12'h0) ? WAIT_MIN :
                      (retry_wait_time > WAIT_MAX) ? WAIT_MAX : retry_wait_time;
  assign retry_limit = (retry_count_limit > RETRY_FAULT_OUT_BASE) ? retry_count_limit - RETRY_FAULT_OUT_BASE :
                       (retry_count_limit > RETRY_MAX_DIRECT) ? RETRY_MAX_DIRECT : retry_count_limit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= start_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  typedef enum logic [2:0] {
    ST_STOP = 3'b000,
    ST_RUN = 3'b001,
    ST_PF_DECEL = 3'b011,
    ST_PF_HOLD = 3'b010,
    ST_RETRY_WAIT = 3'b110,
    ST_TRIP = 3'b111,
    ST_COAST = 3'b101
  } frps_state_type;

  frps_state_type state;
  frps_state_type next_state;
  logic [13:0] tick_cnt;
  logic [6:0] fail_cnt;
  logic in_retry;
  logic need_toggle;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_STOP: begin
        if (any_fault) begin
          next_state = ST_TRIP;
        end else if (start_rise || (start_in && !need_toggle)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_fault) begin
          if (fault_eligible(retry_fault_select, fault_code) && fail_cnt < retry_limit) begin
            next_state = ST_RETRY_WAIT;
          end else begin
            next_state = ST_TRIP;
          end
        end else if (power_fail_detect && !auto_restart_en) begin
          next_state = (power_fail_stop_select == PFS_COAST) ? ST_COAST : ST_PF_DECEL;
        end else if (!start_in) begin
          next_state = ST_STOP;
        end
      end
      ST_PF_DECEL: begin
        if (any_fault) begin
          next_state = ST_TRIP;
        end else if (power_fail_stop_select == PFS_CONTINUE && !power_fail_detect && start_in) begin
          next_state = ST_RUN;
        end else if (freq_zero) begin
          next_state = ST_PF_HOLD;
        end
      end
      ST_PF_HOLD: begin
        if (!power_fail_detect && start_rise) begin
          next_state = ST_RUN;
        end
      end
      ST_RETRY_WAIT: begin
        // The tick runs free, so one extra tick keeps the wait from falling short of the setting
        if (tk_if.tick && tick_cnt >= 14'(wait_ticks)) begin
          next_state = ST_RUN;
        end
      end
      ST_COAST: begin
        if (!power_fail_detect) begin
          next_state = ST_STOP;
        end
      end
      ST_TRIP: next_state = ST_TRIP;
      default: next_state = ST_STOP;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_STOP;
    end else begin
      state <= next_state;
    end
  end

  // A restart after a power-fail stop needs an off-then-on start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      need_toggle <= 1'b0;
    end else if (state == ST_PF_HOLD || state == ST_COAST) begin
      need_toggle <= 1'b1;
    end else if (!start_in) begin
      need_toggle <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retry timers and counters

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= 14'h0;
    end else if (state != next_state) begin
      tick_cnt <= 14'h0;
    end else if (tk_if.tick && tick_cnt != 14'h3fff) begin
      tick_cnt <= tick_cnt + 14'h1;
    end
  end

  logic success_due;
  assign success_due = in_retry && state == ST_RUN && !any_fault && tk_if.tick &&
                       tick_cnt >= 14'(SUCCESS_FACTOR * int'(wait_ticks));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_retry <= 1'b0;
      fail_cnt <= 7'h0;
    end else if (state == ST_RUN && next_state == ST_RETRY_WAIT) begin
      in_retry <= 1'b1;
      fail_cnt <= fail_cnt + 7'h1;
    end else if (success_due || (state == ST_RUN && next_state == ST_STOP)) begin
      in_retry <= 1'b0;
      fail_cnt <= 7'h0;
    end
  end

  // A clear in the same cycle as an increment leaves the count at one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_success_counter <= 16'h0;
    end else if (success_due) begin
      retry_success_counter <= (retry_success_clear ? 16'h0 : retry_success_counter) + 16'h1;
    end else if (retry_success_clear) begin
      retry_success_counter <= 16'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_fault <= '0;
    end else if (state == ST_RUN && any_fault && !in_retry) begin
      first_fault <= fault_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_shutoff <= 1'b1;
      pf_decel_cmd <= 1'b0;
      normal_decel_cmd <= 1'b0;
      reaccel_cmd <= 1'b0;
      run_enable <= 1'b0;
      retry_restart <= 1'b0;
      flying_restart <= 1'b0;
      trip <= 1'b0;
      fault_output <= 1'b0;
      retry_excess_fault <= 1'b0;
      clear_thermal_data <= 1'b1;
      power_fail_decel_flag <= 1'b0;
      retry_active_flag <= 1'b0;
    end else begin
      output_shutoff <= next_state inside {ST_STOP, ST_COAST, ST_TRIP, ST_RETRY_WAIT, ST_PF_HOLD};
      pf_decel_cmd <= next_state == ST_PF_DECEL;
      // Start dropped during a continuation outage falls back to normal decel
      normal_decel_cmd <= next_state == ST_PF_DECEL && power_fail_stop_select == PFS_CONTINUE && !start_in;
      reaccel_cmd <= state == ST_PF_DECEL && next_state == ST_RUN;
      run_enable <= next_state == ST_RUN;
      retry_restart <= state == ST_RETRY_WAIT && next_state == ST_RUN;
      flying_restart <= state == ST_RETRY_WAIT && next_state == ST_RUN && auto_restart_en;
      trip <= next_state == ST_TRIP;
      fault_output <= next_state == ST_TRIP ||
                      (next_state == ST_RETRY_WAIT && retry_count_limit > RETRY_FAULT_OUT_BASE);
      retry_excess_fault <= retry_excess_fault | (state == ST_RUN && any_fault &&
                            fault_eligible(retry_fault_select, fault_code) && in_retry &&
                            fail_cnt >= retry_limit && retry_limit != 7'h0);
      // Only power-on clears thermal data; retry resets leave it alone
      clear_thermal_data <= 1'b0;
      power_fail_decel_flag <= next_state inside {ST_PF_DECEL, ST_PF_HOLD};
      retry_active_flag <= next_state == ST_RETRY_WAIT || (in_retry && next_state == ST_RUN);
    end
  end

  for (genvar i = 0; i < NUM_TERMS; i++) begin : g_term
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        terminal_out[i] <= 1'b0;
      end else begin
        terminal_out[i] <= term_drive(output_terminal_function_select[i], TERM_PFD_POS, TERM_PFD_NEG,
                                      power_fail_decel_flag) |
                           term_drive(output_terminal_function_select[i], TERM_RETRY_POS, TERM_RETRY_NEG,
                                      retry_active_flag);
      end
    end
  end

endmodule : frps_top

/* File: tb/frps_stage_model.sv */
`timescale 1ns/1ps
module frps_stage_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Commands
  input wire logic run_enable,
  input wire logic pf_decel_cmd,
  input wire logic normal_decel_cmd,
  input wire logic output_shutoff,
  // Status
  output logic freq_zero
);
  logic [3:0] speed;
  // Short ramp so that a stop spans only a few cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      speed <= 4'h0;
    end else if ((pf_decel_cmd || normal_decel_cmd || output_shutoff) && speed != 4'h0) begin
      speed <= speed - 4'h1;
    end else if (run_enable && !output_shutoff && speed != 4'h8) begin
      speed <= speed + 4'h1;
    end
  end
  assign freq_zero = (speed == 4'h0);
endmodule : frps_stage_model

/* File: tb/frps_top_sva.sv */
`timescale 1ns/1ps
module frps_top_sva #(
  parameter int TICK_CYC = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic [6:0] retry_count_limit,
  input wire logic [7:0] output_terminal_function_select [frps_pkg::NUM_TERMS],
  input wire logic pf_decel_cmd,
  input wire logic run_enable,
  input wire logic retry_restart,
  input wire logic trip,
  input wire logic fault_output,
  input wire logic retry_excess_fault,
  input wire logic power_fail_decel_flag,
  input wire logic retry_active_flag,
  input wire logic [frps_pkg::NUM_TERMS-1:0] terminal_out,
  input wire logic [15:0] retry_success_counter
);
  import frps_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_pf_flag_on: assert property (pf_decel_cmd |-> power_fail_decel_flag)
    else $error("pf decel without flag");
  chk_term_pfd_pos: assert property (
    $past(arst_n) && output_terminal_function_select[0] == TERM_PFD_POS
    |-> terminal_out[0] == $past(power_fail_decel_flag)) else $error("pf terminal wrong");
  chk_term_retry_neg: assert property (
    $past(arst_n) && output_terminal_function_select[1] == TERM_RETRY_NEG
    |-> terminal_out[1] == !$past(retry_active_flag)) else $error("retry terminal wrong");
  chk_excess_sticky: assert property (retry_excess_fault |=> retry_excess_fault && trip)
    else $error("excess fault dropped");
  chk_excess_no_retry: assert property (retry_excess_fault |-> !retry_restart)
    else $error("retry after excess");
  chk_zero_no_retry: assert property (
    retry_count_limit == 7'h00 && $past(retry_count_limit) == 7'h00 |-> !retry_restart)
    else $error("retry with count zero");
  chk_restart_runs: assert property (retry_restart |-> ##[0:2] run_enable)
    else $error("restart without run");
  chk_success_step: assert property (
    retry_success_counter != $past(retry_success_counter)
    |-> retry_success_counter == $past(retry_success_counter) + 16'h0001 || retry_success_counter == 16'h0000)
    else $error("success count jump");
  chk_fault_out_hi: assert property (
    $rose(retry_active_flag) && retry_count_limit > RETRY_FAULT_OUT_BASE |-> ##[0:1] fault_output)
    else $error("no fault output in retry");
  cov_restart: cover property (retry_restart);
  cov_excess: cover property ($rose(retry_excess_fault));
  cov_success: cover property ($changed(retry_success_counter) && retry_success_counter != 16'h0000);
endmodule : frps_top_sva

bind frps_top frps_top_sva #(.TICK_CYC(TICK_CYC)) frps_top_sva_inst (.clk, .arst_n, .retry_count_limit,
  .output_terminal_function_select, .pf_decel_cmd, .run_enable, .retry_restart, .trip, .fault_output,
  .retry_excess_fault, .power_fail_decel_flag, .retry_active_flag, .terminal_out, .retry_success_counter);

/* File: tb/frps_top_tb.sv */
`timescale 1ns/1ps
module frps_top_tb;
  import frps_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] sel = PFS_STOP;
  logic [2:0] fsel = RSEL_ALL;
  logic [6:0] lim = 7'h00;
  logic [7:0] tsel [NUM_TERMS] = '{TERM_PFD_POS, TERM_RETRY_NEG, TERM_RETRY_POS};
  logic clr = 1'b0;
  logic fwd = 1'b0;
  logic pfd = 1'b0;
  logic [10:0] fc = 11'h000;
  logic [13:0] rct = COAST_DISABLE;
  logic [11:0] wt = 12'h000;
  logic fz, shut, pfdec, ndec, reacc, run, rrst, fly, trip, fout, rex, pflag, ract, cthm;
  logic [2:0] term;
  logic [15:0] scnt;
  logic [10:0] ffirst;
  int mismatches = 0;
  int tests_run = 0;
  wire [7:0] mon = {reacc, rrst, rex, run, pfdec, shut, ract, trip};
  always #25 clk = ~clk;
  frps_top #(.TICK_CYC(10)) frps_top_inst (.clk(clk), .arst_n(arst_n), .power_fail_stop_select(sel),
    .restart_coast_time(rct), .retry_fault_select(fsel), .retry_count_limit(lim),
    .retry_wait_time(wt), .output_terminal_function_select(tsel), .retry_success_clear(clr),
    .forward_start_input(fwd), .reverse_start_input(1'b0), .power_fail_detect(pfd), .freq_zero(fz),
    .fault_code(fc), .output_shutoff(shut), .pf_decel_cmd(pfdec), .normal_decel_cmd(ndec),
    .reaccel_cmd(reacc), .run_enable(run), .retry_restart(rrst), .flying_restart(fly), .trip(trip),
    .fault_output(fout), .retry_excess_fault(rex), .clear_thermal_data(cthm), .power_fail_decel_flag(pflag),
    .retry_active_flag(ract), .terminal_out(term), .retry_success_counter(scnt), .first_fault(ffirst));
  frps_stage_model frps_stage_model_inst (.clk(clk), .arst_n(arst_n), .run_enable(run),
    .pf_decel_cmd(pfdec), .normal_decel_cmd(ndec), .output_shutoff(shut), .freq_zero(fz));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait on one monitored output, then compare it
  task automatic await(input int b, input logic v, input int n);
    #1;
    while (mon[b] !== v && n > 0) begin
      cyc(1);
      n--;
    end
    chk_bit(mon[b], v);
  endtask : await
  task automatic do_reset(input logic [1:0] s, input logic [6:0] l, input logic [2:0] f);
    @(posedge clk);
    arst_n <= 1'b0;
    sel <= s;
    lim <= l;
    fsel <= f;
    fwd <= 1'b0;
    pfd <= 1'b0;
    cyc(12);
    chk_bit(shut, 1'b1);
    chk_bit(cthm, 1'b1);
    chk_val(scnt, 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
  endtask : do_reset
  task automatic start_run;
    @(posedge clk);
    fwd <= 1'b1;
    await(4, 1'b1, 20);
    cyc(10);
  endtask : start_run
  task automatic pulse(input logic [10:0] f);
    @(posedge clk);
    fc <= f;
    @(posedge clk);
    fc <= 11'h000;
  endtask : pulse
  task automatic set_pfd(input logic v);
    @(posedge clk);
    pfd <= v;
  endtask : set_pfd
  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(PFS_STOP, 7'h00, RSEL_ALL);
    set_pfd(1'b1);
    cyc(4);
    chk_bit(pflag, 1'b0);
    set_pfd(1'b0);
    start_run();
    set_pfd(1'b1);
    await(3, 1'b1, 5);
    chk_bit(pflag, 1'b1);
    // Power returns mid-decel: stop mode still runs down to zero
    set_pfd(1'b0);
    await(2, 1'b1, 40);
    chk_bit(pfdec, 1'b0);
    repeat (20) begin
      cyc(1);
      chk_bit(run, 1'b0);
    end
    chk_bit(pflag, 1'b1);
    @(posedge clk);
    fwd <= 1'b0;
    cyc(3);
    start_run();
    // Start stays high through the first outage and drops during the second
    do_reset(PFS_CONTINUE, 7'h00, RSEL_ALL);
    start_run();
    set_pfd(1'b1);
    await(3, 1'b1, 5);
    set_pfd(1'b0);
    await(7, 1'b1, 20);
    cyc(6);
    set_pfd(1'b1);
    await(3, 1'b1, 5);
    @(posedge clk);
    fwd <= 1'b0;
    cyc(1);
    chk_bit(ndec, 1'b1);
    do_reset(PFS_COAST, 7'h00, RSEL_ALL);
    start_run();
    set_pfd(1'b1);
    await(2, 1'b1, 3);
    chk_bit(pfdec, 1'b0);
    // Auto restart selected: power-fail stop is bypassed, retries restart on the fly
    @(posedge clk);
    rct <= 14'h0000;
    do_reset(PFS_STOP, 7'h01, RSEL_ALL);
    start_run();
    set_pfd(1'b1);
    cyc(3);
    chk_bit(pflag, 1'b0);
    chk_bit(run, 1'b1);
    set_pfd(1'b0);
    pulse(11'h001);
    await(6, 1'b1, 30);
    chk_bit(fly, 1'b1);
    chk_bit(cthm, 1'b0);
    @(posedge clk);
    rct <= COAST_DISABLE;
    do_reset(PFS_STOP, 7'h00, RSEL_ALL);
    start_run();
    pulse(11'h001);
    cyc(3);
    chk_bit(ract, 1'b0);
    // Fail twice, then succeed; only the first cause is kept
    do_reset(PFS_STOP, 7'h02, RSEL_ALL);
    start_run();
    pulse(11'h002);
    await(1, 1'b1, 5);
    cyc(1);
    chk_bit(term[2], 1'b1);
    cyc(7);
    chk_bit(run, 1'b0);
    await(6, 1'b1, 30);
    chk_bit(fly, 1'b0);
    pulse(11'h008);
    await(6, 1'b1, 40);
    chk_val({5'h00, ffirst}, 16'h0002);
    await(1, 1'b0, 80);
    cyc(1);
    chk_val(scnt, 16'h0001);
    pulse(11'h001);
    await(6, 1'b1, 40);
    pulse(11'h001);
    await(6, 1'b1, 40);
    chk_bit(rex, 1'b0);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cyc(2);
    chk_val(scnt, 16'h0000);
    @(posedge clk);
    wt <= 12'h002;
    do_reset(PFS_STOP, 7'h65, RSEL_OC);
    start_run();
    pulse(11'h002);
    await(1, 1'b1, 5);
    chk_bit(fout, 1'b1);
    cyc(15);
    chk_bit(run, 1'b0);
    await(6, 1'b1, 40);
    // Held fault makes every retry fail
    do_reset(PFS_STOP, 7'h01, RSEL_ALL);
    start_run();
    @(posedge clk);
    fc <= 11'h004;
    await(5, 1'b1, 200);
    chk_bit(trip, 1'b1);
    @(posedge clk);
    fc <= 11'h000;
    // Thermal and overvoltage faults against each selection
    for (int k = 0; k < 12; k++) begin
      do_reset(PFS_STOP, 7'h01, 3'(k % 6));
      start_run();
      pulse(k < 6 ? 11'h040 : 11'h008);
      cyc(3);
      chk_bit(ract, k < 6 ? k == 0 : (k != 7 && k != 11));
    end
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : frps_top_tb
